// ### hw/wfd_pkg.sv
package wfd_pkg;
    // register port widths and number of patterns
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NPAT   = 4;

    // address = {bank, offset}; offsets are byte addresses of 16-bit registers
    localparam logic [3:0] BANK_CTRL     = 4'h3;
    localparam logic [1:0] BANK_PAT_HI   = 2'h1;   // banks 4..7 hold patterns 0..3
    localparam logic [3:0] BANK_IRQ      = 4'h8;
    localparam logic [3:0] OFF_CTRL      = 4'ha;
    localparam logic [3:0] OFF_CRC_LO    = 4'h0;
    localparam logic [3:0] OFF_CRC_HI    = 4'h2;
    localparam logic [3:0] OFF_MASK_W0   = 4'h4;
    localparam logic [3:0] OFF_MASK_W1   = 4'h6;
    localparam logic [3:0] OFF_MASK_W2   = 4'h8;
    localparam logic [3:0] OFF_MASK_W3   = 4'ha;
    localparam logic [3:0] OFF_IRQ_STAT  = 4'h0;
    localparam logic [3:0] OFF_IRQ_MASK  = 4'h2;

    // control fields and reset values
    localparam int          CTRL_MAGIC_BIT = 7;
    localparam logic [15:0] CTRL_WR_MASK   = 16'h008f;
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [15:0] REG_RST        = 16'h0000;

    // event status layout: bits 0..3 patterns, bit 4 magic packet
    localparam int         ST_W     = 5;
    localparam int         ST_MAGIC = 4;
    localparam logic [4:0] ST_RST   = 5'h00;

    // frame checking
    localparam int          MASK_BYTES = 64;
    localparam logic [6:0]  CNT_MAX    = 7'h40;
    localparam logic [31:0] CRC_INIT   = 32'hffffffff;
    localparam logic [31:0] CRC_POLY   = 32'hedb88320;
    localparam logic [7:0]  SYNC_BYTE  = 8'hff;
    localparam logic [2:0]  MAGIC_SYNC = 3'h6;
    localparam logic [3:0]  MAGIC_LAST = 4'hf;     // sixteen copies of the address
    localparam logic [2:0]  ADDR_LAST  = 3'h5;

    // reflected 802.3 crc, one byte, lsb first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ### hw/wfd_detector.sv
`timescale 1ns/100ps
// Summary of operation
// - magic packet search runs only while control bit 7 is one
// - control bits 0..3 enable pattern detectors 0..3 independently
// - a disabled pattern never matches, whatever its crc and mask hold
// - low half of expected crc is the pattern's first register
// - high half of expected crc is the pattern's second register
// - comparison crc is the 802.3 ethernet crc-32
// - only bytes selected by the pattern's mask enter its crc
// - mask word 0 bit 0..15 selects frame bytes 1..16
// - mask word 1 bit 0..15 selects frame bytes 17..32
// - mask word 2 bit 0..15 selects frame bytes 33..48
// - mask word 3 bit 0..15 selects bytes 49..64; later bytes ignored
module wfd_detector (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    // register port
    input  wire logic [wfd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [wfd_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [wfd_pkg::DATA_W-1:0]  reg_rdata,
    // receive byte stream from the mac
    input  wire logic                        rx_valid,
    input  wire logic [7:0]                  rx_data,
    input  wire logic                        rx_last,
    input  wire logic                        rx_bad,
    input  wire logic [47:0]                 station_addr,
    // wake indications
    output logic                             wake_event,
    output logic                             irq
);

    typedef enum logic [0:0] {WFD_SYNC, WFD_ADDR} wfd_mstate_t;

    logic [15:0]                 ctrl;
    logic [15:0]                 next_ctrl;
    logic [31:0]                 pat_crc      [wfd_pkg::NPAT];
    logic [31:0]                 next_pat_crc [wfd_pkg::NPAT];
    logic [63:0]                 pat_mask      [wfd_pkg::NPAT];
    logic [63:0]                 next_pat_mask [wfd_pkg::NPAT];
    logic [wfd_pkg::ST_W-1:0]    status;
    logic [wfd_pkg::ST_W-1:0]    next_status;
    logic [wfd_pkg::ST_W-1:0]    imask;
    logic [wfd_pkg::ST_W-1:0]    next_imask;
    logic [wfd_pkg::ST_W-1:0]    ev;
    logic [wfd_pkg::NPAT-1:0]    ev_pat;
    logic                        ev_magic;
    logic [15:0]                 next_rdata;
    logic                        next_irq;
    logic                        next_wake;
    logic [6:0]                  byte_cnt;
    logic [6:0]                  next_byte_cnt;
    logic [31:0]                 crc_run      [wfd_pkg::NPAT];
    logic [31:0]                 next_crc_run [wfd_pkg::NPAT];
    logic [31:0]                 crc_fin      [wfd_pkg::NPAT];
    wfd_mstate_t                 mstate;
    wfd_mstate_t                 next_mstate;
    logic [2:0]                  ff_cnt;
    logic [2:0]                  next_ff_cnt;
    logic [2:0]                  addr_idx;
    logic [2:0]                  next_addr_idx;
    logic [3:0]                  rep_cnt;
    logic [3:0]                  next_rep_cnt;
    logic                        magic_hit;
    logic                        next_magic_hit;

    // position of the highest selected byte, 1-based; 0 when none selected
    function automatic logic [6:0] top_pos(input logic [63:0] m);
        logic [6:0] h;
        h = 7'h00;
        for (int i = 0; i < wfd_pkg::MASK_BYTES; i++) begin
            if (m[i]) begin
                h = 7'(i + 1);
            end
        end
        return h;
    endfunction

    // the address splits into bank and byte offset
    function automatic logic is_reg(input logic [7:0] a, input logic [3:0] bank,
                                    input logic [3:0] off);
        return (a[7:4] == bank) && (a[3:0] == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file: decode, writes, read data and interrupt state
    always_comb begin
        logic [1:0] p;
        logic       pat_sel;
        p             = reg_addr[5:4];
        pat_sel       = (reg_addr[7:6] == wfd_pkg::BANK_PAT_HI);
        next_ctrl     = ctrl;
        next_pat_crc  = pat_crc;
        next_pat_mask = pat_mask;
        next_imask    = imask;
        next_rdata    = 16'h0000;
        next_status   = status;
        if (reg_wr) begin
            if (is_reg(reg_addr, wfd_pkg::BANK_CTRL, wfd_pkg::OFF_CTRL)) begin
                next_ctrl = reg_wdata & wfd_pkg::CTRL_WR_MASK;
            end
            if (is_reg(reg_addr, wfd_pkg::BANK_IRQ, wfd_pkg::OFF_IRQ_STAT)) begin
                next_status = status & ~reg_wdata[wfd_pkg::ST_W-1:0];
            end
            if (is_reg(reg_addr, wfd_pkg::BANK_IRQ, wfd_pkg::OFF_IRQ_MASK)) begin
                next_imask = reg_wdata[wfd_pkg::ST_W-1:0];
            end
            if (pat_sel) begin
                case (reg_addr[3:0])
                    wfd_pkg::OFF_CRC_LO:  next_pat_crc[p][15:0]   = reg_wdata;
                    wfd_pkg::OFF_CRC_HI:  next_pat_crc[p][31:16]  = reg_wdata;
                    wfd_pkg::OFF_MASK_W0: next_pat_mask[p][15:0]  = reg_wdata;
                    wfd_pkg::OFF_MASK_W1: next_pat_mask[p][31:16] = reg_wdata;
                    wfd_pkg::OFF_MASK_W2: next_pat_mask[p][47:32] = reg_wdata;
                    wfd_pkg::OFF_MASK_W3: next_pat_mask[p][63:48] = reg_wdata;
                    default: ;
                endcase
            end
        end
        // set beats clear so an event landing on a clear write is kept
        next_status = next_status | ev;
        if (reg_rd) begin
            if (is_reg(reg_addr, wfd_pkg::BANK_CTRL, wfd_pkg::OFF_CTRL)) begin
                next_rdata = ctrl;
            end
            if (is_reg(reg_addr, wfd_pkg::BANK_IRQ, wfd_pkg::OFF_IRQ_STAT)) begin
                next_rdata = {11'h000, status};
            end
            if (is_reg(reg_addr, wfd_pkg::BANK_IRQ, wfd_pkg::OFF_IRQ_MASK)) begin
                next_rdata = {11'h000, imask};
            end
            if (pat_sel) begin
                case (reg_addr[3:0])
                    wfd_pkg::OFF_CRC_LO:  next_rdata = pat_crc[p][15:0];
                    wfd_pkg::OFF_CRC_HI:  next_rdata = pat_crc[p][31:16];
                    wfd_pkg::OFF_MASK_W0: next_rdata = pat_mask[p][15:0];
                    wfd_pkg::OFF_MASK_W1: next_rdata = pat_mask[p][31:16];
                    wfd_pkg::OFF_MASK_W2: next_rdata = pat_mask[p][47:32];
                    wfd_pkg::OFF_MASK_W3: next_rdata = pat_mask[p][63:48];
                    default: next_rdata = 16'h0000;
                endcase
            end
        end
        next_irq  = |(next_status & next_imask);
        next_wake = |ev;
    end

    // register file flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl      <= wfd_pkg::CTRL_RST;
            status    <= wfd_pkg::ST_RST;
            imask     <= wfd_pkg::ST_RST;
            reg_rdata <= wfd_pkg::REG_RST;
            irq       <= 1'b0;
            wake_event <= 1'b0;
            for (int i = 0; i < wfd_pkg::NPAT; i++) begin
                pat_crc[i]  <= 32'h00000000;
                pat_mask[i] <= 64'h0000000000000000;
            end
        end else begin
            ctrl       <= next_ctrl;
            status     <= next_status;
            imask      <= next_imask;
            reg_rdata  <= next_rdata;
            irq        <= next_irq;
            wake_event <= next_wake;
            pat_crc    <= next_pat_crc;
            pat_mask   <= next_pat_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one event vector, each part owned by a single process
    assign ev = {ev_magic, ev_pat};

    // pattern engines: all four run side by side on every byte
    always_comb begin
        next_byte_cnt = byte_cnt;
        next_crc_run  = crc_run;
        ev_pat        = '0;
        for (int p = 0; p < wfd_pkg::NPAT; p++) begin
            crc_fin[p] = crc_run[p];
            // bytes past 64 never reach the crc
            if (rx_valid && byte_cnt < wfd_pkg::CNT_MAX && pat_mask[p][byte_cnt[5:0]]) begin
                crc_fin[p] = wfd_pkg::crc_byte(crc_run[p], rx_data);
            end
            next_crc_run[p] = crc_fin[p];
            if (rx_valid && rx_last) begin
                next_crc_run[p] = wfd_pkg::CRC_INIT;
                // count of this frame includes the last byte
                ev_pat[p] = ctrl[p] && !rx_bad
                        && (7'(byte_cnt + 7'h01) >= top_pos(pat_mask[p]))
                        && (~crc_fin[p] == pat_crc[p]);
            end
        end
        if (rx_valid) begin
            if (rx_last) begin
                next_byte_cnt = 7'h00;
            end else if (byte_cnt < wfd_pkg::CNT_MAX) begin
                next_byte_cnt = 7'(byte_cnt + 7'h01);
            end
        end
    end

    // pattern engine flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_cnt <= 7'h00;
            for (int i = 0; i < wfd_pkg::NPAT; i++) begin
                crc_run[i] <= wfd_pkg::CRC_INIT;
            end
        end else begin
            byte_cnt <= next_byte_cnt;
            crc_run  <= next_crc_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // magic packet: six sync bytes then sixteen copies of the station address
    always_comb begin
        logic [7:0] want;
        logic       is_ff;
        want           = station_addr[8'(47 - 8 * addr_idx) -: 8];
        is_ff          = (rx_data == wfd_pkg::SYNC_BYTE);
        next_mstate    = mstate;
        next_ff_cnt    = ff_cnt;
        next_addr_idx  = addr_idx;
        next_rep_cnt   = rep_cnt;
        next_magic_hit = magic_hit;
        ev_magic       = 1'b0;
        if (rx_valid) begin
            case (mstate)
                WFD_SYNC: begin
                    next_ff_cnt = is_ff ? 3'(ff_cnt + 3'h1) : 3'h0;
                    if (is_ff && ff_cnt == 3'(wfd_pkg::MAGIC_SYNC - 3'h1)) begin
                        next_mstate   = WFD_ADDR;
                        next_addr_idx = 3'h0;
                        next_rep_cnt  = 4'h0;
                    end
                end
                WFD_ADDR: begin
                    if (rx_data == want) begin
                        next_addr_idx = (addr_idx == wfd_pkg::ADDR_LAST) ? 3'h0
                                                                         : 3'(addr_idx + 3'h1);
                        if (addr_idx == wfd_pkg::ADDR_LAST) begin
                            next_rep_cnt = 4'(rep_cnt + 4'h1);
                            if (rep_cnt == wfd_pkg::MAGIC_LAST) begin
                                next_magic_hit = 1'b1;
                                next_mstate    = WFD_SYNC;
                                next_ff_cnt    = 3'h0;
                            end
                        end
                    end else if (!(is_ff && addr_idx == 3'h0 && rep_cnt == 4'h0)) begin
                        // a long sync run is tolerated; any other miss restarts
                        next_mstate = WFD_SYNC;
                        next_ff_cnt = is_ff ? 3'h1 : 3'h0;
                    end
                end
                default: next_mstate = WFD_SYNC;
            endcase
            if (rx_last) begin
                ev_magic = ctrl[wfd_pkg::CTRL_MAGIC_BIT] && !rx_bad
                           && next_magic_hit;
                next_mstate    = WFD_SYNC;
                next_ff_cnt    = 3'h0;
                next_magic_hit = 1'b0;
            end
        end
        // search held idle while disabled
        if (!ctrl[wfd_pkg::CTRL_MAGIC_BIT]) begin
            next_mstate    = WFD_SYNC;
            next_ff_cnt    = 3'h0;
            next_magic_hit = 1'b0;
        end
    end

    // magic search flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mstate    <= WFD_SYNC;
            ff_cnt    <= 3'h0;
            addr_idx  <= 3'h0;
            rep_cnt   <= 4'h0;
            magic_hit <= 1'b0;
        end else begin
            mstate    <= next_mstate;
            ff_cnt    <= next_ff_cnt;
            addr_idx  <= next_addr_idx;
            rep_cnt   <= next_rep_cnt;
            magic_hit <= next_magic_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic wr_p0;
    assign wr_p0 = reg_wr && reg_addr[7:4] == 4'h4;

    chk_magic_gated: assert property (@(posedge mclk) disable iff (sys_rst)
        !ctrl[wfd_pkg::CTRL_MAGIC_BIT] |-> ##1 !status[wfd_pkg::ST_MAGIC] || $past(status[4]))
        else $error("magic event while disabled");
    chk_pattern_gated: assert property (@(posedge mclk) disable iff (sys_rst)
        (ev[3:0] & ~ctrl[3:0]) == 4'h0)
        else $error("pattern event while disabled");
    chk_crc_low: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_p0 && reg_addr[3:0] == 4'h0 |=> pat_crc[0][15:0] == $past(reg_wdata))
        else $error("crc low half not stored");
    chk_crc_high: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_p0 && reg_addr[3:0] == 4'h2 |=> pat_crc[0][31:16] == $past(reg_wdata))
        else $error("crc high half not stored");
    chk_crc_compare: assert property (@(posedge mclk) disable iff (sys_rst)
        ev[0] |-> ~crc_fin[0] == pat_crc[0] ##1 wake_event)
        else $error("match without equal crc or no wake");
    chk_mask_skip: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_valid && !rx_last && byte_cnt < 7'h40 && !pat_mask[1][byte_cnt[5:0]]
        |=> crc_run[1] == $past(crc_run[1]))
        else $error("unselected byte changed crc");
    chk_mask_word0: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_p0 && reg_addr[3:0] == 4'h4 |=> pat_mask[0][15:0] == $past(reg_wdata))
        else $error("mask word 0 misplaced");
    chk_mask_word1: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_p0 && reg_addr[3:0] == 4'h6 |=> pat_mask[0][31:16] == $past(reg_wdata))
        else $error("mask word 1 misplaced");
    chk_mask_word2: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_p0 && reg_addr[3:0] == 4'h8 |=> pat_mask[0][47:32] == $past(reg_wdata))
        else $error("mask word 2 misplaced");
    chk_late_bytes: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_valid && !rx_last && byte_cnt == 7'h40 |=> crc_run[0] == $past(crc_run[0]))
        else $error("byte past 64 entered crc");
    chk_short_frame: assert property (@(posedge mclk) disable iff (sys_rst)
        ev[2] |-> 7'(byte_cnt + 7'h01) >= top_pos(pat_mask[2]))
        else $error("short frame matched");
    chk_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 irq == |(status & imask))
        else $error("irq not following status and mask");

    cov_pattern_hit: cover property (@(posedge mclk) disable iff (sys_rst) ev[0] ##1 irq);
    cov_magic_hit:   cover property (@(posedge mclk) disable iff (sys_rst) ev[wfd_pkg::ST_MAGIC]);
    cov_all_hit:     cover property (@(posedge mclk) disable iff (sys_rst) ev[3:0] == 4'hf);

endmodule

// ### verification/wfd_mac_model.sv
`timescale 1ns/100ps
// receive path model: sends one frame per call from its byte buffer
module wfd_mac_model (
    // clock
    input  wire logic       mclk,
    // byte stream towards the detector
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic            rx_bad
);
    logic [7:0] frm [0:127];

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        rx_bad   = 1'b0;
    end

    // gap leaves an idle cycle between bytes, as a slow mac would
    task automatic send(input int n, input logic bad, input logic gap);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_data  <= frm[i];
            rx_last  <= (i == n - 1);
            rx_bad   <= bad && (i == n - 1);
            if (gap && i < n - 1) begin
                @(posedge mclk);
                rx_valid <= 1'b0;
                rx_data  <= ~frm[i]; // idle data never repeats the stale byte
            end
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_data  <= ~frm[n - 1];
        rx_last  <= 1'b0;
        rx_bad   <= 1'b0;
    endtask
endmodule

// ### verification/wfd_detector_tb.sv
`timescale 1ns/100ps
module wfd_detector_tb;
    logic        mclk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_last;
    logic        rx_bad;
    logic [47:0] station_addr;
    logic        wake_event;
    logic        irq;
    int          fails;
    int          check_count;
    int          cycles;
    logic [63:0] msk [0:3];

    wfd_detector wfd_detector_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_bad(rx_bad),
        .station_addr(station_addr), .wake_event(wake_event), .irq(irq));
    wfd_mac_model wfd_mac_model_i (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_bad(rx_bad));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 check({16'h0000, reg_rdata}, {16'h0000, exp});
    endtask

    // reference fcs over the masked bytes, lsb first, complemented
    function automatic logic [31:0] ref_crc(input int n, input logic [63:0] m);
        logic [31:0] c;
        c = wfd_pkg::CRC_INIT;
        for (int j = 0; j < 64; j++) begin
            for (int b = 0; b < 8; b++) begin
                if (m[j] && j < n)
                    c = (c[0] ^ wfd_mac_model_i.frm[j][b]) ? ((c >> 1) ^ wfd_pkg::CRC_POLY)
                                                           : (c >> 1);
            end
        end
        return ~c;
    endfunction

    task automatic set_pat(input int p, input logic [31:0] crc);
        logic [7:0] base;
        base = 8'h40 + 8'(p * 16);
        wr(base, crc[15:0]);
        wr(base + 8'h02, crc[31:16]);
        for (int k = 0; k < 4; k++)
            wr(base + 8'h04 + 8'(2 * k), msk[p][16 * k +: 16]);
    endtask

    task automatic t_regs;
        rd_chk(8'h3a, 16'h0000);
        wr(8'h3a, 16'hffff);
        rd_chk(8'h3a, 16'h008f);
        wr(8'h40, 16'h1234);
        wr(8'h42, 16'habcd);
        rd_chk(8'h40, 16'h1234);
        rd_chk(8'h42, 16'habcd);
        rd_chk(8'h41, 16'h0000);
        rd_chk(8'h2c, 16'h0000);
        wr(8'h3a, 16'h0000);
    endtask

    // bytes 1 and 64, 17 and 33, 16 with a wrong crc, 32; frame runs past 64
    task automatic t_match;
        for (int i = 0; i < 128; i++)
            wfd_mac_model_i.frm[i] = 8'(i * 7 + 3);
        msk[0] = 64'h8000_0000_0000_0001;
        msk[1] = 64'h0000_0001_0001_0000;
        msk[2] = 64'h0000_0000_0000_8000;
        msk[3] = 64'h0000_0000_8000_0000;
        for (int p = 0; p < 4; p++)
            set_pat(p, (p == 2) ? ~ref_crc(70, msk[p]) : ref_crc(70, msk[p]));
        wr(8'h3a, 16'h000f);
        wfd_mac_model_i.send(70, 1'b0, 1'b1);
        #1 check(wake_event, 1'b1);
        @(posedge mclk);
        #1 check(wake_event, 1'b0);
        rd_chk(8'h80, 16'h000b);
        wr(8'h80, 16'h001f);
        rd_chk(8'h80, 16'h0000);
    endtask

    // short frame fails only patterns needing later bytes
    task automatic t_short_disabled;
        // crc of pattern 0 fits the 40 bytes sent; only its byte 64 rejects it
        set_pat(0, ref_crc(40, msk[0]));
        wfd_mac_model_i.send(40, 1'b0, 1'b0);
        rd_chk(8'h80, 16'h000a);
        wr(8'h80, 16'h001f);
        wr(8'h3a, 16'h0002);
        wfd_mac_model_i.send(70, 1'b0, 1'b0);
        rd_chk(8'h80, 16'h0002);
        wr(8'h80, 16'h001f);
        wr(8'h3a, 16'h0000);
        wfd_mac_model_i.send(70, 1'b0, 1'b0);
        #1 check(wake_event, 1'b0);
        // pattern 1 still holds a matching crc, so only the error flag stops it
        wr(8'h3a, 16'h0002);
        wfd_mac_model_i.send(70, 1'b1, 1'b0);
        #1 check(wake_event, 1'b0);
        rd_chk(8'h80, 16'h0000);
    endtask

    // six sync bytes then sixteen address copies
    task automatic t_magic_irq;
        for (int i = 0; i < 102; i++)
            wfd_mac_model_i.frm[i] = (i < 6) ? 8'hff : station_addr[47 - 8 * ((i - 6) % 6) -: 8];
        wr(8'h3a, 16'h0000);
        wfd_mac_model_i.send(102, 1'b0, 1'b0);
        rd_chk(8'h80, 16'h0000);
        wr(8'h82, 16'h0010);
        wr(8'h3a, 16'h0080);
        wfd_mac_model_i.send(102, 1'b0, 1'b0);
        #1 check(irq, 1'b1);
        rd_chk(8'h80, 16'h0010);
        wr(8'h82, 16'h0000);
        repeat (2) @(posedge mclk);
        #1 check(irq, 1'b0);
        wr(8'h82, 16'h0010);
        repeat (2) @(posedge mclk);
        #1 check(irq, 1'b1);
        wr(8'h80, 16'h0010);
        repeat (2) @(posedge mclk);
        #1 check(irq, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst      = 1'b1;
        reg_addr     = 8'h00;
        reg_wdata    = 16'h0000;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        station_addr = 48'h0a1b2c3d4e5f;
        fails        = 0;
        check_count  = 0;
        cycles       = 0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_match();
        t_short_disabled();
        t_magic_irq();
        end_sim();
    end
endmodule
